// ===== serial_unit_pkg.sv
/*
 * Constants for the serial unit register block in two-wire mode.
 * Assumes register indices are word indices on a 32-bit classic Wishbone bus.
 */
`default_nettype none
package serial_unit_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CONTROL_ONE = 8'he9;
    localparam logic [7:0] IDX_CONTROL_TWO = 8'hea;
    localparam logic [7:0] IDX_CONTROL_THREE = 8'heb;
    localparam logic [7:0] IDX_CONTROL_FOUR = 8'hec;
    localparam logic [7:0] IDX_OWN_SLAVE_ADDRESS = 8'hed;
    localparam logic [7:0] IDX_STATUS_ONE = 8'hf1;
    localparam logic [7:0] IDX_STATUS_TWO = 8'hf2;
    localparam logic [7:0] IDX_BAUD_DIVIDER = 8'hf3;
    localparam logic [7:0] IDX_SDA_HOLD_TIME = 8'hf4;
    localparam logic [7:0] IDX_DATA_BUFFER = 8'hf5;
    localparam logic [7:0] IDX_SCL_LOW_PERIOD = 8'hf6;
    localparam logic [7:0] IDX_SCL_HIGH_PERIOD = 8'hf7;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hf8;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf9;
    localparam logic [7:0] IDX_PIN_STATE = 8'hfa;
    // Values after reset.
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_STATUS_ONE = 8'h80;
    localparam logic [7:0] RST_BAUD_DIVIDER = 8'hff;
    localparam logic [7:0] RST_SDA_HOLD_TIME = 8'h01;
    localparam logic [7:0] RST_SCL_PERIOD = 8'h3f;
    // Field positions.
    localparam int CTL1_MODE_HI = 7;
    localparam int CTL1_MODE_LO = 6;
    localparam int CTL2_ENABLE_BIT = 1;
    localparam int CTL4_MASTER_BIT = 0;
    localparam int CTL4_ACK_BIT = 1;
    localparam int ST1_DRE_BIT = 7;
    localparam int ST2_SSEL_BIT = 0;
    localparam int ST2_TEND_BIT = 1;
    localparam int ST2_STOP_BIT = 2;
    localparam int SAR_GCALL_BIT = 0;
    // Operating modes.
    localparam logic [1:0] MODE_ASYNC = 2'b00;
    localparam logic [1:0] MODE_I2C = 2'b10;
    localparam logic [1:0] MODE_SPI = 2'b11;
    // Cycle counts.
    localparam logic [8:0] HOLD_EXTRA = 9'h002;
    localparam logic [9:0] PERIOD_EXTRA = 10'h002;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [4:0] SPI_EDGES = 5'h10;

    typedef enum logic [1:0] {
        SL_IDLE = 2'b00,
        SL_ADDR = 2'b01,
        SL_DATA = 2'b10,
        SL_ACK = 2'b11
    } slave_state_t;
endpackage : serial_unit_pkg
`default_nettype wire

// ===== serial_unit_i2c.sv
/*
 * Serial unit in two-wire mode: registers on classic Wishbone, open-drain pins,
 * master clock generation, slave address match, SDA hold timing and interrupts.
 * Assumes external pull-ups and a pad ring that resolves the open-drain enables.
 */
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module serial_unit_i2c
    import serial_unit_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Wishbone slave.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Two-wire pins, open drain.
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Port control.
    input wire logic pin_function_in,
    input wire logic pullup_enable_in,
    output logic scl_pullup_out,
    output logic sda_pullup_out,
    // Other modes and interrupt.
    output logic spi_serial_clock_out,
    output logic baud_tick_out,
    output logic irq_out
);
    logic [7:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d, ctl3_q, ctl3_d, ctl4_q, ctl4_d;
    logic [7:0] sar_q, sar_d, st1_q, st1_d, st2_q, st2_d, baud_q, baud_d;
    logic [7:0] hold_q, hold_d, rxbuf_q, rxbuf_d, scl_low_q, scl_low_d, scl_high_q, scl_high_d;
    logic [7:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
    logic [31:0] rdat_d;
    logic ack_d, wb_take, wr_en;
    logic [7:0] idx, wbyte;
    logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_f_d;
    slave_state_t slv_q, slv_d;
    logic [7:0] shift_q, shift_d, tx_shift_q, tx_shift_d;
    logic [3:0] bit_cnt_q, bit_cnt_d, tx_cnt_q, tx_cnt_d;
    logic [8:0] hold_cnt_q, hold_cnt_d;
    logic [9:0] scl_cnt_q, scl_cnt_d;
    logic scl_gen_q, scl_gen_d, sda_oe_d, scl_oe_d, tx_low_q, tx_low_d;
    logic [7:0] baud_cnt_q, baud_cnt_d;
    logic spi_busy_q, spi_busy_d, spi_clk_q, spi_clk_d, baud_tick_d;
    logic [4:0] spi_edges_q, spi_edges_d;
    logic [2:0] ev_set;
    logic i2c_on, master_run, ack_en, scl_rise, scl_fall, start_w, stop_w, addr_hit;
    logic data_wr, sda_low_want, spi_master, async_on;

    assign idx = wb_adr_in[9:2];
    assign wbyte = wb_dat_in[7:0];
    assign wb_take = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr_en = wb_take & wb_we_in & wb_sel_in[0];
    assign data_wr = wr_en & (idx == IDX_DATA_BUFFER);
    assign i2c_on = (ctl1_q[CTL1_MODE_HI:CTL1_MODE_LO] == MODE_I2C) & ctl2_q[CTL2_ENABLE_BIT] & pin_function_in;
    assign async_on = (ctl1_q[CTL1_MODE_HI:CTL1_MODE_LO] == MODE_ASYNC) & ctl2_q[CTL2_ENABLE_BIT];
    assign spi_master = (ctl1_q[CTL1_MODE_HI:CTL1_MODE_LO] == MODE_SPI) & ctl2_q[CTL2_ENABLE_BIT]
        & ctl4_q[CTL4_MASTER_BIT];
    assign master_run = i2c_on & ctl4_q[CTL4_MASTER_BIT];
    assign ack_en = ctl4_q[CTL4_ACK_BIT];
    // Pull-up follows the port control setting only.
    assign scl_pullup_out = pullup_enable_in;
    assign sda_pullup_out = pullup_enable_in;
    // Open-drain pins only ever pull low.
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign irq_out = |(irq_st_q & irq_mask_q);

    // Pin edge and condition detection on the filtered latch.
    assign scl_rise = ~pin_f_q[0] & pin_f_d[0];
    assign scl_fall = pin_f_q[0] & ~pin_f_d[0];
    assign start_w = pin_f_q[0] & pin_f_d[0] & pin_f_q[1] & ~pin_f_d[1];
    assign stop_w = pin_f_q[0] & pin_f_d[0] & ~pin_f_q[1] & pin_f_d[1];
    // Own address, baud divider used as address, or general call.
    assign addr_hit = (shift_q[7:1] == sar_q[7:1]) | (shift_q[7:1] == baud_q[7:1])
        | (sar_q[SAR_GCALL_BIT] & (shift_q[7:1] == 7'h00));

    // Register file and bus answers.
    always_comb
    begin
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        ctl3_d = ctl3_q;
        ctl4_d = ctl4_q;
        sar_d = sar_q;
        st1_d = st1_q;
        baud_d = baud_q;
        hold_d = hold_q;
        scl_low_d = scl_low_q;
        scl_high_d = scl_high_q;
        irq_mask_d = irq_mask_q;
        st2_d = st2_q;
        irq_st_d = irq_st_q;
        if (wr_en)
        begin
            case (idx)
                IDX_CONTROL_ONE: ctl1_d = wbyte;
                IDX_CONTROL_TWO: ctl2_d = wbyte;
                IDX_CONTROL_THREE: ctl3_d = wbyte;
                IDX_CONTROL_FOUR: ctl4_d = wbyte;
                IDX_OWN_SLAVE_ADDRESS: sar_d = wbyte;
                IDX_STATUS_ONE: st1_d = {st1_q[ST1_DRE_BIT], wbyte[6:0]};
                IDX_STATUS_TWO: st2_d = st2_q & wbyte;
                IDX_BAUD_DIVIDER: baud_d = wbyte;
                IDX_SDA_HOLD_TIME: hold_d = wbyte;
                IDX_SCL_LOW_PERIOD: scl_low_d = wbyte;
                IDX_SCL_HIGH_PERIOD: scl_high_d = wbyte;
                IDX_IRQ_STATUS: irq_st_d = irq_st_q & ~wbyte;
                IDX_IRQ_MASK: irq_mask_d = wbyte;
                default: ;
            endcase
        end
        // Hardware events win over a clear in the same cycle.
        st2_d = st2_d | {5'h00, ev_set};
        irq_st_d = irq_st_d | {5'h00, ev_set};
        // Empty flag clears on a data write and sets when the byte has gone out.
        if (data_wr)
        begin
            st1_d[ST1_DRE_BIT] = 1'b0;
        end
        if (((tx_cnt_q == 4'h1) & master_run & scl_fall)
            | (spi_busy_q & (spi_edges_q == 5'h01) & (baud_cnt_q == 8'h00)))
        begin
            st1_d[ST1_DRE_BIT] = 1'b1;
        end
        rdat_d = 32'h0000_0000;
        case (idx)
            IDX_CONTROL_ONE: rdat_d[7:0] = ctl1_q;
            IDX_CONTROL_TWO: rdat_d[7:0] = ctl2_q;
            IDX_CONTROL_THREE: rdat_d[7:0] = ctl3_q;
            IDX_CONTROL_FOUR: rdat_d[7:0] = ctl4_q;
            IDX_OWN_SLAVE_ADDRESS: rdat_d[7:0] = sar_q;
            IDX_STATUS_ONE: rdat_d[7:0] = st1_q;
            IDX_STATUS_TWO: rdat_d[7:0] = st2_q;
            IDX_BAUD_DIVIDER: rdat_d[7:0] = baud_q;
            IDX_SDA_HOLD_TIME: rdat_d[7:0] = hold_q;
            IDX_DATA_BUFFER: rdat_d[7:0] = rxbuf_q;
            IDX_SCL_LOW_PERIOD: rdat_d[7:0] = scl_low_q;
            IDX_SCL_HIGH_PERIOD: rdat_d[7:0] = scl_high_q;
            IDX_IRQ_STATUS: rdat_d[7:0] = irq_st_q;
            IDX_IRQ_MASK: rdat_d[7:0] = irq_mask_q;
            IDX_PIN_STATE: rdat_d[1:0] = pin_f_q;
            default: rdat_d = 32'h0000_0000;
        endcase
        if (!wb_take || wb_we_in)
        begin
            rdat_d = wb_dat_out;
        end
        ack_d = wb_take;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ctl1_q <= RST_ZERO;
            ctl2_q <= RST_ZERO;
            ctl3_q <= RST_ZERO;
            ctl4_q <= RST_ZERO;
            sar_q <= RST_ZERO;
            st1_q <= RST_STATUS_ONE;
            st2_q <= RST_ZERO;
            baud_q <= RST_BAUD_DIVIDER;
            hold_q <= RST_SDA_HOLD_TIME;
            scl_low_q <= RST_SCL_PERIOD;
            scl_high_q <= RST_SCL_PERIOD;
            irq_st_q <= RST_ZERO;
            irq_mask_q <= RST_ZERO;
            wb_dat_out <= 32'h0000_0000;
            wb_ack_out <= 1'b0;
        end
        else
        begin
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
            ctl3_q <= ctl3_d;
            ctl4_q <= ctl4_d;
            sar_q <= sar_d;
            st1_q <= st1_d;
            st2_q <= st2_d;
            baud_q <= baud_d;
            hold_q <= hold_d;
            scl_low_q <= scl_low_d;
            scl_high_q <= scl_high_d;
            irq_st_q <= irq_st_d;
            irq_mask_q <= irq_mask_d;
            wb_dat_out <= rdat_d;
            wb_ack_out <= ack_d;
        end
    end

    // Link side: pin filter, slave engine, master clock, hold timer, baud counter.
    always_comb
    begin
        pin_f_d = ((pin_s2_q ~^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_f_q);
        slv_d = slv_q;
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        rxbuf_d = rxbuf_q;
        ev_set = 3'b000;
        if (!i2c_on)
        begin
            slv_d = SL_IDLE;
        end
        else if (start_w)
        begin
            slv_d = SL_ADDR;
            bit_cnt_d = 4'h0;
        end
        else if (stop_w)
        begin
            ev_set[ST2_STOP_BIT] = (slv_q == SL_DATA) | (slv_q == SL_ACK);
            slv_d = SL_IDLE;
        end
        else
        begin
            case (slv_q)
                SL_IDLE: ;
                SL_ADDR, SL_DATA:
                begin
                    if (scl_rise && bit_cnt_q != BITS_PER_BYTE)
                    begin
                        shift_d = {shift_q[6:0], pin_f_q[1]};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_q == BITS_PER_BYTE)
                    begin
                        if (slv_q == SL_ADDR)
                        begin
                            // Match with acknowledge selects the slave.
                            ev_set[ST2_SSEL_BIT] = addr_hit & ack_en;
                            slv_d = (addr_hit & ack_en) ? SL_ACK : SL_IDLE;
                        end
                        else
                        begin
                            rxbuf_d = shift_q;
                            ev_set[ST2_TEND_BIT] = 1'b1;
                            slv_d = SL_ACK;
                        end
                    end
                end
                SL_ACK:
                begin
                    if (scl_fall)
                    begin
                        slv_d = SL_DATA;
                        bit_cnt_d = 4'h0;
                    end
                end
                default: slv_d = SL_IDLE;
            endcase
        end
        // Master clock: reload at each edge, run only as master.
        scl_gen_d = scl_gen_q;
        scl_cnt_d = scl_cnt_q;
        if (!master_run)
        begin
            scl_gen_d = 1'b1;
            scl_cnt_d = {scl_high_q, 2'b00} + PERIOD_EXTRA - 10'h001;
        end
        else if (scl_cnt_q == 10'h000)
        begin
            scl_gen_d = ~scl_gen_q;
            scl_cnt_d = (scl_gen_q ? {scl_low_q, 2'b00} : {scl_high_q, 2'b00}) + PERIOD_EXTRA - 10'h001;
        end
        else
        begin
            scl_cnt_d = scl_cnt_q - 10'h001;
        end
        // Transmit shifter takes the data buffer write.
        tx_shift_d = tx_shift_q;
        tx_cnt_d = tx_cnt_q;
        if (data_wr)
        begin
            tx_shift_d = wbyte;
            tx_cnt_d = BITS_PER_BYTE;
        end
        else if (master_run && scl_fall && tx_cnt_q != 4'h0)
        begin
            tx_shift_d = {tx_shift_q[6:0], 1'b1};
            tx_cnt_d = tx_cnt_q - 4'h1;
        end
        // The top bit is latched before the shift, so the byte leaves MSB first.
        tx_low_d = tx_low_q;
        if (!master_run)
        begin
            tx_low_d = 1'b0;
        end
        else if (scl_fall)
        begin
            tx_low_d = (tx_cnt_q != 4'h0) & ~tx_shift_q[7];
        end
        sda_low_want = (slv_q == SL_ACK & ack_en) | (master_run & tx_low_q);
        // Hold timer restarts at each SCL fall; SDA moves when it expires.
        hold_cnt_d = hold_cnt_q;
        sda_oe_d = sda_oe_out;
        if (i2c_on && scl_fall)
        begin
            hold_cnt_d = {1'b0, hold_q} + HOLD_EXTRA;
        end
        else if (hold_cnt_q != 9'h000)
        begin
            hold_cnt_d = hold_cnt_q - 9'h001;
        end
        if (!i2c_on)
        begin
            sda_oe_d = 1'b0;
        end
        else if (hold_cnt_q == 9'h001)
        begin
            sda_oe_d = sda_low_want;
        end
        // Stretch in the acknowledge state while any status two source is set, or master low phase.
        scl_oe_d = i2c_on & (((slv_q == SL_ACK) & (st2_q != 8'h00)) | (master_run & ~scl_gen_q));
        // Baud counter times async bits and the SPI clock.
        baud_cnt_d = baud_cnt_q;
        spi_busy_d = spi_busy_q;
        spi_edges_d = spi_edges_q;
        spi_clk_d = spi_clk_q;
        baud_tick_d = 1'b0;
        if (spi_master && data_wr)
        begin
            spi_busy_d = 1'b1;
            spi_edges_d = SPI_EDGES;
            baud_cnt_d = baud_q;
        end
        else if (async_on || spi_busy_q)
        begin
            if (baud_cnt_q == 8'h00)
            begin
                baud_cnt_d = baud_q;
                baud_tick_d = async_on;
                if (spi_busy_q)
                begin
                    spi_clk_d = ~spi_clk_q;
                    spi_edges_d = spi_edges_q - 5'h01;
                    spi_busy_d = spi_edges_q != 5'h01;
                end
            end
            else
            begin
                baud_cnt_d = baud_cnt_q - 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pin_s1_q <= 2'b11;
            pin_s2_q <= 2'b11;
            pin_s3_q <= 2'b11;
            pin_f_q <= 2'b11;
            slv_q <= SL_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            rxbuf_q <= 8'h00;
            scl_gen_q <= 1'b1;
            scl_cnt_q <= 10'h000;
            tx_shift_q <= 8'h00;
            tx_cnt_q <= 4'h0;
            tx_low_q <= 1'b0;
            hold_cnt_q <= 9'h000;
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
            baud_cnt_q <= 8'h00;
            spi_busy_q <= 1'b0;
            spi_edges_q <= 5'h00;
            spi_clk_q <= 1'b0;
            baud_tick_out <= 1'b0;
        end
        else
        begin
            pin_s1_q <= {sda_in, scl_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q <= pin_f_d;
            slv_q <= slv_d;
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            rxbuf_q <= rxbuf_d;
            scl_gen_q <= scl_gen_d;
            scl_cnt_q <= scl_cnt_d;
            tx_shift_q <= tx_shift_d;
            tx_cnt_q <= tx_cnt_d;
            tx_low_q <= tx_low_d;
            hold_cnt_q <= hold_cnt_d;
            sda_oe_out <= sda_oe_d;
            scl_oe_out <= scl_oe_d;
            baud_cnt_q <= baud_cnt_d;
            spi_busy_q <= spi_busy_d;
            spi_edges_q <= spi_edges_d;
            spi_clk_q <= spi_clk_d;
            baud_tick_out <= baud_tick_d;
        end
    end
    assign spi_serial_clock_out = spi_clk_q;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_open_drain: assert property (!scl_out && !sda_out) else $error("pin driven high");
    a_pin_read: assert property (wb_take && !wb_we_in && idx == IDX_PIN_STATE
        |=> wb_ack_out && wb_dat_out[1:0] == $past(pin_f_q)) else $error("pin read wrong");
    a_data_write: assert property (data_wr |=> tx_shift_q == $past(wbyte) && !st1_q[ST1_DRE_BIT])
        else $error("data write lost");
    a_spi_start: assert property (spi_master && data_wr |=> spi_busy_q && spi_edges_q == SPI_EDGES)
        else $error("spi clock not started");
    a_hold_load: assert property (i2c_on && scl_fall |=> hold_cnt_q == {1'b0, $past(hold_q)} + HOLD_EXTRA)
        else $error("hold count not loaded");
    a_sda_timing: assert property (i2c_on && hold_cnt_q == 9'h001 ##1 i2c_on |-> sda_oe_out == $past(sda_low_want))
        else $error("sda change late");
    a_scl_high: assert property (master_run && $rose(scl_gen_q) |-> scl_cnt_q == {scl_high_q, 2'b00} + 10'h001)
        else $error("high period wrong");
    a_scl_low: assert property (master_run && $fell(scl_gen_q) |-> scl_cnt_q == {scl_low_q, 2'b00} + 10'h001)
        else $error("low period wrong");
    a_slave_select: assert property (slv_q == SL_ADDR && scl_fall && bit_cnt_q == BITS_PER_BYTE && addr_hit
        && ack_en && i2c_on && !start_w && !stop_w |=> st2_q[ST2_SSEL_BIT] && slv_q == SL_ACK ##1 scl_oe_out)
        else $error("slave select missed");
    a_gcall_ignore: assert property (slv_q == SL_ADDR && scl_fall && bit_cnt_q == BITS_PER_BYTE
        && shift_q[7:1] == 7'h00 && !sar_q[SAR_GCALL_BIT] && sar_q[7:1] != 7'h00 && baud_q[7:1] != 7'h00
        && i2c_on && !start_w && !stop_w |=> slv_q == SL_IDLE) else $error("general call accepted");
    a_scl_stretch: assert property (i2c_on && slv_q == SL_ACK && st2_q != 8'h00 |=> scl_oe_out)
        else $error("scl released early");
endmodule : serial_unit_i2c
`default_nettype wire

// ===== i2c_far_end.sv
/* Far-side two-wire master model with pull-ups on both lines.
   Assumes one task call at a time, made just after a clk_in edge. */
`timescale 1ns/10ps
`default_nettype none
module i2c_far_end (
    // Clock and device enables.
    input wire logic clk_in,
    input wire logic scl_oe_in,
    input wire logic sda_oe_in,
    // Resolved wire levels.
    output logic scl_out,
    output logic sda_out
);
    logic pull_scl_q = 1'b0;
    logic pull_sda_q = 1'b0;
    // Pull-ups make a released line high.
    assign scl_out = !(scl_oe_in || pull_scl_q);
    assign sda_out = !(sda_oe_in || pull_sda_q);
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    task automatic release_scl();
        int k;
        k = 0;
        pull_scl_q <= 1'b0;
        tick(1);
        while (scl_out !== 1'b1 && k < 4000)
        begin
            tick(1);
            k++;
        end
        tick(8);
    endtask : release_scl
    task automatic send_byte(input logic [7:0] b);
        pull_sda_q <= 1'b1;
        tick(8);
        for (int i = 7; i >= 0; i--)
        begin
            pull_scl_q <= 1'b1;
            tick(4);
            pull_sda_q <= !b[i];
            tick(4);
            release_scl();
        end
        pull_scl_q <= 1'b1;
        pull_sda_q <= 1'b0;
        tick(8);
    endtask : send_byte
    task automatic stop_bus();
        release_scl();
        pull_scl_q <= 1'b1;
        tick(8);
        pull_sda_q <= 1'b1;
        tick(8);
        release_scl();
        pull_sda_q <= 1'b0;
        tick(8);
    endtask : stop_bus
endmodule : i2c_far_end
`default_nettype wire

// ===== serial_unit_i2c_register_interface_test.sv
/* Self-checking bench for the two-wire serial unit.
   Assumes the far-side master model and a 25 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module serial_unit_i2c_register_interface_test
    import serial_unit_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pull_en = 1'b0, pin_fn = 1'b1;
    logic [9:0] adr = '0;
    logic [31:0] wdat = '0, rdat;
    logic ack, scl, sda, scl_oe, sda_oe, scl_o, sda_o, scl_pu, sda_pu, tick, spi_clk, irq;
    logic [7:0] r;
    int n_mismatch = 0, total_checks = 0, n, h;
    logic [31:0] rows [19] = '{32'he900_0000, 32'hea00_0000, 32'heb00_0000, 32'hec00_0000, 32'hed00_0000,
        32'hf100_0080, 32'hf200_0000, 32'hf300_00ff, 32'hf400_0001, 32'hf500_0000, 32'hf600_003f,
        32'hf700_003f, 32'hf800_0000, 32'hf900_0000, 32'h1000_0000, 32'heb01_a5a5, 32'hf201_ff00,
        32'h1001_5a00, 32'hf501_3c00};
    logic [23:0] cases [5] = '{24'h54_5401, 24'h54_5600, 24'h54_0000, 24'h55_0001, 24'h54_fe01};
    serial_unit_i2c dut (.core_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .pin_function_in(pin_fn), .pullup_enable_in(pull_en),
        .scl_pullup_out(scl_pu), .sda_pullup_out(sda_pu), .spi_serial_clock_out(spi_clk),
        .baud_tick_out(tick), .irq_out(irq));
    i2c_far_end far (.clk_in(clk), .scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    initial forever #20 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1 && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 100)
            n_mismatch++;
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic span(input logic lvl);
        logic s;
        s = sda_oe;
        n = 0;
        h = 0;
        while (scl_oe === lvl && n < 500)
        begin
            @(posedge clk);
            n++;
            if (h == 0 && sda_oe !== s)
                h = n;
        end
    endtask : span
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i])
        begin
            if (rows[i][23:16] != 8'h00)
                wb(1'b1, rows[i][31:24], rows[i][15:8]);
            wb(1'b0, rows[i][31:24], 8'h00);
            chk("register", r, rows[i][7:0]);
        end
        $display("register table done");
        pull_en <= 1'b1;
        wb(1'b1, IDX_CONTROL_ONE, 8'h80);
        wb(1'b1, IDX_CONTROL_TWO, 8'h02);
        wb(1'b1, IDX_CONTROL_FOUR, 8'h02);
        wb(1'b1, IDX_SDA_HOLD_TIME, RST_SDA_HOLD_TIME);
        wb(1'b1, IDX_IRQ_MASK, 8'h01);
        wb(1'b0, IDX_PIN_STATE, 8'h00);
        chk("pin_state", r, 8'h03);
        chk("scl_pullup", scl_pu, 1);
        chk("sda_pullup", sda_pu, 1);
        chk("pin_out", {scl_o, sda_o}, 0);
        foreach (cases[i])
        begin
            wb(1'b1, IDX_OWN_SLAVE_ADDRESS, cases[i][23:16]);
            far.send_byte(cases[i][15:8]);
            repeat (12) @(posedge clk);
            wb(1'b0, IDX_STATUS_TWO, 8'h00);
            chk("status_two", r, cases[i][7:0]);
            chk("scl_hold", scl_oe, cases[i][0]);
            chk("irq", irq, cases[i][0]);
            wb(1'b1, IDX_IRQ_MASK, 8'h00);
            chk("irq_masked", irq, 0);
            wb(1'b1, IDX_STATUS_TWO, 8'h00);
            wb(1'b1, IDX_IRQ_STATUS, 8'hff);
            wb(1'b1, IDX_IRQ_MASK, 8'h01);
            chk("scl_free", scl_oe, 0);
            chk("irq_clear", irq, 0);
            far.stop_bus();
            wb(1'b1, IDX_STATUS_TWO, 8'h00);
            wb(1'b1, IDX_IRQ_STATUS, 8'hff);
        end
        $display("slave match done");
        wb(1'b1, IDX_CONTROL_FOUR, 8'h01);
        wb(1'b1, IDX_SCL_LOW_PERIOD, 8'h03);
        wb(1'b1, IDX_SCL_HIGH_PERIOD, 8'h02);
        // The byte loaded by the register table goes out first; wait for the buffer to empty.
        n = 0;
        r = 8'h00;
        while (r[7] !== 1'b1 && n < 400)
        begin
            wb(1'b0, IDX_STATUS_ONE, 8'h00);
            n++;
        end
        chk("dre", r[7], 1);
        wb(1'b1, IDX_DATA_BUFFER, 8'h55);
        for (int j = 0; j < 3; j++)
        begin
            span(1'b0);
            span(1'b1);
        end
        chk("scl_low", n, 14);
        // The pin synchroniser and filter take four edges before the fall is seen.
        chk("sda_hold", h, 32'd4 + RST_SDA_HOLD_TIME + 32'd2);
        span(1'b0);
        chk("scl_high", n, 10);
        repeat (300) @(posedge clk);
        span(1'b0);
        pin_fn <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pin_fn_off", scl_oe, 0);
        $display("master timing done");
        wb(1'b1, IDX_CONTROL_ONE, 8'hc0);
        wb(1'b1, IDX_BAUD_DIVIDER, 8'h02);
        chk("spi_idle", spi_clk, 0);
        wb(1'b1, IDX_DATA_BUFFER, 8'ha5);
        repeat (8) @(posedge clk);
        chk("spi_clock", spi_clk, 1);
        $display("spi done");
        repeat (60) @(posedge clk);
        chk("spi_end", spi_clk, 0);
        wb(1'b1, IDX_CONTROL_ONE, 8'h00);
        n = 0;
        repeat (30)
        begin
            @(posedge clk);
            if (tick === 1'b1)
                n++;
        end
        chk("baud_tick", n, 10);
        $display("async done");
        complete_run();
    end
endmodule : serial_unit_i2c_register_interface_test
`default_nettype wire
